// >>> riapog_defines.svh
// Shared constants for the RTC bus access and power-on gating ends
`ifndef RIAPOG_DEFINES_SVH
`define RIAPOG_DEFINES_SVH
// ****************
// Bus addressing
// ****************
`define RIAPOG_DEV_ADDR 7'h32
`define RIAPOG_FLAG_REG 8'h1e
`define RIAPOG_SEC_REG 8'h10
`define RIAPOG_SEC_WRAP 8'h3b
`define RIAPOG_MEM_WORDS 256
// ****************
// Clock and timing
// ****************
`define RIAPOG_CLK_HZ 250000000
`define RIAPOG_CLK_KHZ 250000
`define RIAPOG_OSC_HZ 32768
`define RIAPOG_OSC_DIV (`RIAPOG_CLK_HZ / `RIAPOG_OSC_HZ)
`define RIAPOG_TIMEOUT_S 2
`define RIAPOG_TIMEOUT_TICKS (`RIAPOG_TIMEOUT_S * `RIAPOG_OSC_HZ)
`define RIAPOG_STABLE_TICKS 32768
`define RIAPOG_SCL_HZ 400000
`define RIAPOG_QDIV ((`RIAPOG_CLK_HZ + 4 * `RIAPOG_SCL_HZ - 1) / (4 * `RIAPOG_SCL_HZ))
`define RIAPOG_BLACKOUT_MS 40
`define RIAPOG_BLACKOUT_CYC (`RIAPOG_BLACKOUT_MS * `RIAPOG_CLK_KHZ)
`define RIAPOG_OSC_START_MS 1000
`define RIAPOG_OSC_START_CYC (`RIAPOG_OSC_START_MS * `RIAPOG_CLK_KHZ)
`define RIAPOG_RSTWAIT_MS 2
`define RIAPOG_RSTWAIT_CYC (`RIAPOG_RSTWAIT_MS * `RIAPOG_CLK_KHZ + 1)
// ****************
// Software reset writes, {register, data}
// ****************
`define RIAPOG_RST_W0 16'h3200
`define RIAPOG_RST_W1 16'h3f80
`define RIAPOG_RST_W2 16'hd06c
`define RIAPOG_RST_W3 16'hd103
`define RIAPOG_RST_W4 16'hd210
`define RIAPOG_RST_W5 16'hd320
`define RIAPOG_RST_STEPS 3'h6
`endif

// >>> riapog_pkg.sv
// Types shared by the RTC bus ends
package riapog_pkg;
   typedef enum logic [2:0] {D_IDLE, D_ADDR, D_REG, D_WDATA, D_RDATA, D_SKIP} riapog_dev_e;
   typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} riapog_eng_e;
   typedef enum logic [2:0] {O_START, O_DEVW, O_REG, O_DATA, O_DEVR, O_RECV, O_STOP, O_END}
      riapog_op_e;
   typedef enum logic [2:0] {P_OFF, P_BLACK, P_FLAG, P_OSC, P_READY, P_USER, P_RST, P_RWAIT}
      riapog_phase_e;
endpackage : riapog_pkg

// >>> riapog_if.sv
// Open-drain two-wire bus joining host and RTC ends
`timescale 1ns/1ps
interface riapog_if;
   logic sclHostOe;
   logic sdaHostOe;
   logic sdaDevOe;
   logic scl;
   logic sda;
   // Wired-AND: a line is low while any party pulls it
   assign scl = !sclHostOe;
   assign sda = !(sdaHostOe || sdaDevOe);
   modport host(output sclHostOe, output sdaHostOe, input scl, input sda);
   modport device(output sdaDevOe, input scl, input sda);
endinterface : riapog_if

// >>> riapog_device.sv
// RTC target end: bus access, timeout, power-on reset and time gating
`timescale 1ns/1ps
`include "riapog_defines.svh"
// Overview of operation
// - Bus interface idles 2 s after address
// - Host sends fresh START after timeout
// - Write byte stored at ACK clock rise
// - Partial byte at stop is discarded
// - Backup supply rise forces power-on reset
// - Registers valid only once oscillator is stable
// - Host first reads the supply loss flag
// - Flag set: init after oscillator start time
// - No access for 40 ms after supply
// - Without proper rise, software initialisation
// - Software reset writes fixed sequence, waits
// - Dummy read: any address, ignore ACK
// - Time counting pauses during bus transfer
module riapog_device #(
   parameter int OSC_DIV = `RIAPOG_OSC_DIV,
   parameter int TIMEOUT_TICKS = `RIAPOG_TIMEOUT_TICKS,
   parameter int STABLE_TICKS = `RIAPOG_STABLE_TICKS,
   parameter int SEC_TICKS = `RIAPOG_OSC_HZ
) (
   input wire logic sys_clk,
   input wire logic rst,
   riapog_if.device bus,
   input wire logic supplyRise,
   output logic oscStable,
   output logic supplyLoss,
   output logic busBusy,
   output logic [7:0] seconds
);
   if (OSC_DIV < 2 || OSC_DIV > 65535 || TIMEOUT_TICKS < 1 || TIMEOUT_TICKS > 16777215 ||
       STABLE_TICKS < 1 || STABLE_TICKS > 16777215 || SEC_TICKS < 1 || SEC_TICKS > 16777215)
   begin : gBadParam
      $error("riapog_device: parameter out of range");
   end

   localparam logic [15:0] OSC_LIM = 16'(OSC_DIV - 1);
   localparam logic [23:0] TO_LIM = 24'(TIMEOUT_TICKS - 1);
   localparam logic [23:0] STAB_LIM = 24'(STABLE_TICKS - 1);
   localparam logic [23:0] SEC_LIM = 24'(SEC_TICKS - 1);

   // ****************
   // Line sampling and power-on reset
   // ****************
   logic sclQ;
   logic sdaQ;
   logic supplyQ;
   wire startDet = sclQ && bus.scl && sdaQ && !bus.sda;
   wire stopDet = sclQ && bus.scl && !sdaQ && bus.sda;
   wire sclRise = !sclQ && bus.scl;
   wire sclFall = sclQ && !bus.scl;
   wire porPulse = supplyRise && !supplyQ;
   wire iRst = rst || porPulse;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sclQ <= 1'b1;
         sdaQ <= 1'b1;
         // Held at the powered level so leaving reset is not taken as a rise
         supplyQ <= 1'b1;
      end
      else
      begin
         sclQ <= bus.scl;
         sdaQ <= bus.sda;
         supplyQ <= supplyRise;
      end
   end

   // ****************
   // Oscillator tick, stability and timeout
   // ****************
   logic [15:0] oscCnt;
   logic oscTick;
   logic [23:0] stabCnt;
   logic toRun;
   logic [23:0] toCnt;
   riapog_pkg::riapog_dev_e state;
   logic [3:0] bitCnt;
   wire ackRise = sclRise && bitCnt == 4'h8;
   wire addrHit = ackRise && state == riapog_pkg::D_ADDR;
   wire timedOut = toRun && oscTick && toCnt == TO_LIM;

   always_ff @(posedge sys_clk)
   begin
      if (iRst || oscCnt == OSC_LIM)
      begin
         oscCnt <= 16'h0000;
         oscTick <= !iRst;
      end
      else
      begin
         oscCnt <= oscCnt + 16'h0001;
         oscTick <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (iRst)
      begin
         stabCnt <= 24'h000000;
         oscStable <= 1'b0;
      end
      else if (oscTick && !oscStable)
      begin
         oscStable <= stabCnt == STAB_LIM;
         stabCnt <= stabCnt + 24'h000001;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (iRst || startDet || stopDet || timedOut)
      begin
         toRun <= 1'b0;
         toCnt <= 24'h000000;
      end
      else if (addrHit)
         toRun <= 1'b1;
      else if (toRun && oscTick)
         toCnt <= toCnt + 24'h000001;
   end

   // ****************
   // Byte engine
   // ****************
   logic [7:0] mem [`RIAPOG_MEM_WORDS];
   logic [7:0] shiftIn;
   logic [7:0] shiftOut;
   logic [7:0] ptr;
   logic hostNack;
   wire active = state != riapog_pkg::D_IDLE && state != riapog_pkg::D_SKIP;
   wire wrEn = ackRise && state == riapog_pkg::D_WDATA && !timedOut;

   // Special locations show live state instead of the array
   function automatic logic [7:0] rdByte(input logic [7:0] a);
      if (a == `RIAPOG_FLAG_REG)
         rdByte = {7'h00, supplyLoss};
      else if (a == `RIAPOG_SEC_REG)
         rdByte = seconds;
      else
         rdByte = mem[a];
   endfunction : rdByte

   wire [7:0] rdNow = rdByte(ptr);
   wire [2:0] outIdx = 3'(4'h7 - bitCnt);
   wire goRead = (state == riapog_pkg::D_ADDR && shiftIn[0]) ||
                 (state == riapog_pkg::D_RDATA && !hostNack);

   always_ff @(posedge sys_clk)
   begin
      if (iRst)
      begin
         state <= riapog_pkg::D_IDLE;
         bitCnt <= 4'h0;
         shiftIn <= 8'h00;
         shiftOut <= 8'h00;
         ptr <= 8'h00;
         hostNack <= 1'b0;
         bus.sdaDevOe <= 1'b0;
      end
      else if (timedOut || stopDet)
      begin
         state <= riapog_pkg::D_IDLE;
         bitCnt <= 4'h0;
         bus.sdaDevOe <= 1'b0;
      end
      else if (startDet)
      begin
         state <= riapog_pkg::D_ADDR;
         bitCnt <= 4'h0;
         bus.sdaDevOe <= 1'b0;
      end
      else if (active && sclRise)
      begin
         if (bitCnt < 4'h8)
         begin
            shiftIn <= {shiftIn[6:0], bus.sda};
            bitCnt <= bitCnt + 4'h1;
         end
         else if (bitCnt == 4'h8)
         begin
            bitCnt <= 4'h9;
            if (state == riapog_pkg::D_REG)
               ptr <= shiftIn;
            else if (state == riapog_pkg::D_WDATA)
               ptr <= ptr + 8'h01;
            else if (state == riapog_pkg::D_RDATA)
            begin
               hostNack <= bus.sda;
               if (!bus.sda)
                  ptr <= ptr + 8'h01;
            end
         end
      end
      else if (active && sclFall)
      begin
         if (bitCnt == 4'h8)
         begin
            if (state == riapog_pkg::D_RDATA)
               bus.sdaDevOe <= 1'b0;
            else if (state == riapog_pkg::D_ADDR && shiftIn[7:1] != `RIAPOG_DEV_ADDR)
               state <= riapog_pkg::D_SKIP;
            else
               bus.sdaDevOe <= 1'b1;
         end
         else if (bitCnt == 4'h9)
         begin
            bitCnt <= 4'h0;
            if (goRead)
            begin
               state <= riapog_pkg::D_RDATA;
               shiftOut <= rdNow;
               bus.sdaDevOe <= !rdNow[7];
            end
            else
            begin
               bus.sdaDevOe <= 1'b0;
               unique case (state)
                  riapog_pkg::D_ADDR: state <= riapog_pkg::D_REG;
                  riapog_pkg::D_RDATA: state <= riapog_pkg::D_SKIP;
                  default: state <= riapog_pkg::D_WDATA;
               endcase
            end
         end
         else if (state == riapog_pkg::D_RDATA)
            bus.sdaDevOe <= !shiftOut[outIdx];
      end
   end

   // ****************
   // Storage, flag and seconds
   // ****************
   // Only the ACK edge writes, so a byte cut short never lands
   always_ff @(posedge sys_clk)
   begin
      if (iRst)
      begin
         for (int i = 0; i < `RIAPOG_MEM_WORDS; i++)
            mem[i] <= 8'h00;
      end
      else if (wrEn)
         mem[ptr] <= shiftIn;
   end

   logic [23:0] secCnt;

   always_ff @(posedge sys_clk)
   begin
      if (iRst)
      begin
         supplyLoss <= 1'b1;
         busBusy <= 1'b0;
         secCnt <= 24'h000000;
         seconds <= 8'h00;
      end
      else
      begin
         busBusy <= state != riapog_pkg::D_IDLE;
         if (wrEn && ptr == `RIAPOG_FLAG_REG && !shiftIn[0])
            supplyLoss <= 1'b0;
         if (wrEn && ptr == `RIAPOG_SEC_REG)
         begin
            seconds <= shiftIn;
            secCnt <= 24'h000000;
         end
         // Counting stops while the bus is busy, so time is lost
         else if (oscTick && oscStable && !busBusy)
         begin
            secCnt <= (secCnt == SEC_LIM) ? 24'h000000 : secCnt + 24'h000001;
            if (secCnt == SEC_LIM)
               seconds <= (seconds >= `RIAPOG_SEC_WRAP) ? 8'h00 : seconds + 8'h01;
         end
      end
   end
endmodule : riapog_device

// >>> riapog_host.sv
// Host end: power-up gating, flag check, register access, software reset
`timescale 1ns/1ps
`include "riapog_defines.svh"
module riapog_host #(
   parameter int QDIV = `RIAPOG_QDIV,
   parameter int BLACKOUT_CYC = `RIAPOG_BLACKOUT_CYC,
   parameter int OSC_START_CYC = `RIAPOG_OSC_START_CYC,
   parameter int RSTWAIT_CYC = `RIAPOG_RSTWAIT_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   riapog_if.host bus,
   input wire logic supplyGood,
   input wire logic cmdValid,
   input wire logic cmdRead,
   input wire logic [7:0] cmdReg,
   input wire logic [7:0] cmdData,
   input wire logic swResetReq,
   output logic cmdReady,
   output logic rspValid,
   output logic [7:0] rspData,
   output logic rspNack,
   output logic initRequired
);
   if (QDIV < 2 || QDIV > 65535 || BLACKOUT_CYC < 1 || OSC_START_CYC < 1 || RSTWAIT_CYC < 1)
   begin : gBadParam
      $error("riapog_host: parameter out of range");
   end

   localparam logic [15:0] Q_LIM = 16'(QDIV - 1);
   localparam logic [31:0] BLACK_LIM = 32'(BLACKOUT_CYC - 1);
   localparam logic [31:0] OSC_LIM = 32'(OSC_START_CYC - 1);
   localparam logic [31:0] RW_LIM = 32'(RSTWAIT_CYC - 1);

   function automatic riapog_pkg::riapog_op_e opAt(input logic rd, input logic [2:0] s);
      if (rd)
         unique case (s)
            3'h0: opAt = riapog_pkg::O_START;
            3'h1: opAt = riapog_pkg::O_DEVW;
            3'h2: opAt = riapog_pkg::O_REG;
            3'h3: opAt = riapog_pkg::O_START;
            3'h4: opAt = riapog_pkg::O_DEVR;
            3'h5: opAt = riapog_pkg::O_RECV;
            3'h6: opAt = riapog_pkg::O_STOP;
            default: opAt = riapog_pkg::O_END;
         endcase
      else
         unique case (s)
            3'h0: opAt = riapog_pkg::O_START;
            3'h1: opAt = riapog_pkg::O_DEVW;
            3'h2: opAt = riapog_pkg::O_REG;
            3'h3: opAt = riapog_pkg::O_DATA;
            3'h4: opAt = riapog_pkg::O_STOP;
            default: opAt = riapog_pkg::O_END;
         endcase
   endfunction : opAt

   function automatic logic [15:0] rstStep(input logic [2:0] i);
      unique case (i)
         3'h0: rstStep = `RIAPOG_RST_W0;
         3'h1: rstStep = `RIAPOG_RST_W1;
         3'h2: rstStep = `RIAPOG_RST_W2;
         3'h3: rstStep = `RIAPOG_RST_W3;
         3'h4: rstStep = `RIAPOG_RST_W4;
         3'h5: rstStep = `RIAPOG_RST_W5;
         default: rstStep = 16'h0000;
      endcase
   endfunction : rstStep

   // ****************
   // Bit engine
   // ****************
   logic [15:0] qCnt;
   logic qTick;
   riapog_pkg::riapog_eng_e eng;
   logic [1:0] qPh;
   logic [3:0] bitIdx;
   logic [7:0] txB;
   logic [7:0] rxB;
   logic nackBit;
   logic jBusy, jRead, jDummy, jNack, jDone;
   logic [7:0] jReg, jData;
   logic [2:0] step;
   logic lGo, lRead, lDummy;
   logic [7:0] lReg, lData;
   wire riapog_pkg::riapog_op_e op = opAt(jRead, step);
   wire [2:0] stopStep = jRead ? 3'h6 : 3'h4;
   wire [7:0] opByte = (op == riapog_pkg::O_DEVW) ? {`RIAPOG_DEV_ADDR, 1'b0} :
                       (op == riapog_pkg::O_DEVR) ? {`RIAPOG_DEV_ADDR, 1'b1} :
                       (op == riapog_pkg::O_REG) ? jReg :
                       (op == riapog_pkg::O_DATA) ? jData : 8'hff;
   wire sendNack = nackBit && op != riapog_pkg::O_RECV && !jDummy;

   always_ff @(posedge sys_clk)
   begin
      qTick <= !rst && qCnt == Q_LIM;
      qCnt <= (rst || qCnt == Q_LIM) ? 16'h0000 : qCnt + 16'h0001;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         eng <= riapog_pkg::E_IDLE;
         {jBusy, jRead, jDummy, jNack, jDone, nackBit} <= 6'h00;
         {jReg, jData, txB, rxB} <= 32'h00000000;
         {step, qPh, bitIdx} <= 9'h000;
         bus.sclHostOe <= 1'b0;
         bus.sdaHostOe <= 1'b0;
      end
      else
      begin
         jDone <= 1'b0;
         if (lGo)
         begin
            {jBusy, jRead, jDummy, jNack} <= {1'b1, lRead, lDummy, 1'b0};
            {jReg, jData, step} <= {lReg, lData, 3'h0};
         end
         else if (jBusy && eng == riapog_pkg::E_IDLE)
         begin
            {qPh, bitIdx, txB} <= {2'h0, 4'h0, opByte};
            unique case (op)
               riapog_pkg::O_START: eng <= riapog_pkg::E_START;
               riapog_pkg::O_STOP: eng <= riapog_pkg::E_STOP;
               riapog_pkg::O_END: {jBusy, jDone} <= 2'b01;
               default: eng <= riapog_pkg::E_BIT;
            endcase
         end
         else if (qTick && eng != riapog_pkg::E_IDLE)
         begin
            qPh <= qPh + 2'h1;
            unique case (eng)
               riapog_pkg::E_START:
                  unique case (qPh)
                     2'h0: bus.sdaHostOe <= 1'b0;
                     2'h1: bus.sclHostOe <= 1'b0;
                     2'h2: bus.sdaHostOe <= 1'b1;
                     2'h3: {bus.sclHostOe, eng, step} <= {1'b1, riapog_pkg::E_IDLE, step + 3'h1};
                  endcase
               riapog_pkg::E_STOP:
                  unique case (qPh)
                     2'h0: bus.sdaHostOe <= 1'b1;
                     2'h1: bus.sclHostOe <= 1'b0;
                     2'h2: bus.sdaHostOe <= 1'b0;
                     2'h3: {eng, step} <= {riapog_pkg::E_IDLE, step + 3'h1};
                  endcase
               default:
                  unique case (qPh)
                     2'h0: bus.sdaHostOe <= bitIdx < 4'h8 && !txB[7];
                     2'h1: bus.sclHostOe <= 1'b0;
                     2'h2:
                        if (bitIdx < 4'h8)
                           rxB <= {rxB[6:0], bus.sda};
                        else
                           nackBit <= bus.sda;
                     2'h3:
                     begin
                        bus.sclHostOe <= 1'b1;
                        if (bitIdx == 4'h8)
                        begin
                           eng <= riapog_pkg::E_IDLE;
                           jNack <= jNack || sendNack;
                           step <= sendNack ? stopStep : step + 3'h1;
                        end
                        else
                           {bitIdx, txB} <= {bitIdx + 4'h1, txB[6:0], 1'b1};
                     end
                  endcase
            endcase
         end
      end
   end

   // ****************
   // Power-up and command sequencing
   // ****************
   riapog_pkg::riapog_phase_e phase;
   logic [31:0] timer;
   logic [2:0] rIdx;
   wire [15:0] rstNow = rstStep(rIdx);

   always_ff @(posedge sys_clk)
   begin
      if (rst || !supplyGood)
      begin
         phase <= riapog_pkg::P_OFF;
         timer <= 32'h00000000;
         {lGo, lRead, lDummy, lReg, lData, rIdx} <= 22'h000000;
         {cmdReady, rspValid, rspNack, initRequired, rspData} <= 12'h000;
      end
      else
      begin
         lGo <= 1'b0;
         rspValid <= 1'b0;
         timer <= timer + 32'h00000001;
         unique case (phase)
            riapog_pkg::P_OFF:
               {phase, timer} <= {riapog_pkg::P_BLACK, 32'h00000000};
            riapog_pkg::P_BLACK:
               if (timer == BLACK_LIM)
               begin
                  {lGo, lRead, lDummy, lReg} <= {3'b110, `RIAPOG_FLAG_REG};
                  phase <= riapog_pkg::P_FLAG;
               end
            riapog_pkg::P_FLAG:
               if (jDone)
               begin
                  timer <= 32'h00000000;
                  if (jNack)
                     phase <= riapog_pkg::P_OFF;
                  else if (rxB[0])
                     phase <= riapog_pkg::P_OSC;
                  else
                     {phase, cmdReady} <= {riapog_pkg::P_READY, 1'b1};
               end
            riapog_pkg::P_OSC:
               if (timer == OSC_LIM)
                  {phase, cmdReady, initRequired} <= {riapog_pkg::P_READY, 2'b11};
            riapog_pkg::P_READY:
               if (swResetReq)
               begin
                  {lGo, lRead, lDummy, lReg, rIdx} <= {3'b111, `RIAPOG_FLAG_REG, 3'h0};
                  {phase, cmdReady} <= {riapog_pkg::P_RST, 1'b0};
               end
               else if (cmdValid)
               begin
                  {lGo, lRead, lDummy, lReg, lData} <= {1'b1, cmdRead, 1'b0, cmdReg, cmdData};
                  {phase, cmdReady} <= {riapog_pkg::P_USER, 1'b0};
                  if (!cmdRead)
                     initRequired <= 1'b0;
               end
            riapog_pkg::P_USER:
               if (jDone)
               begin
                  {rspValid, rspData, rspNack, cmdReady} <= {1'b1, rxB, jNack, 1'b1};
                  phase <= riapog_pkg::P_READY;
               end
            riapog_pkg::P_RST:
               if (jDone && rIdx == `RIAPOG_RST_STEPS)
                  {phase, timer} <= {riapog_pkg::P_RWAIT, 32'h00000000};
               else if (jDone)
               begin
                  {lGo, lRead, lDummy, lReg, lData} <= {3'b100, rstNow};
                  rIdx <= rIdx + 3'h1;
               end
            riapog_pkg::P_RWAIT:
               if (timer == RW_LIM)
                  {phase, cmdReady, initRequired} <= {riapog_pkg::P_READY, 2'b11};
         endcase
      end
   end
endmodule : riapog_host

// >>> riapog_sva.sv
// Concurrent checks on the host-to-RTC bus and device status
`timescale 1ns/1ps
module riapog_sva (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sdaDevOe,
   input wire logic supplyRise,
   input wire logic supplyGood,
   input wire logic busBusy,
   input wire logic [7:0] seconds,
   input wire logic supplyLoss,
   input wire logic oscStable,
   input wire logic cmdReady
);
   // ****************
   // Properties
   // ****************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence por_s;
      $rose(supplyRise);
   endsequence
   sequence cleared_s;
      supplyLoss && seconds == 8'h00 && !oscStable;
   endsequence
   pause_count_a: assert property (busBusy && $past(busBusy) |-> $stable(seconds))
      else $error("seconds moved during a transfer");
   seconds_step_a: assert property ($changed(seconds) |->
      seconds == $past(seconds) + 8'h01 || seconds == 8'h00)
      else $error("seconds jumped");
   por_clear_a: assert property (por_s |-> ##[1:3] cleared_s)
      else $error("supply rise did not reset the device");
   osc_wait_a: assert property (por_s |-> ##3 !oscStable [*8])
      else $error("oscillator stable too early");
   ack_start_a: assert property ($rose(sdaDevOe) |-> !scl)
      else $error("device pulled data while clock high");
   bus_hold_a: assert property (scl && $past(scl) |-> $stable(sdaDevOe))
      else $error("device data moved while clock high");
   blackout_a: assert property ($fell(rst) |-> (scl && sda) [*8])
      else $error("bus used during blackout");
   no_supply_a: assert property (!supplyGood [*3] |-> !cmdReady)
      else $error("host ready without supply");
endmodule : riapog_sva

// >>> riapog_test.sv
// Bench: host and RTC ends joined, plus a bit-banged second device
`timescale 1ns/1ps
module riapog_test;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic supplyRise = 1'b1;
   logic supplyGood = 1'b1;
   logic cmdValid = 1'b0;
   logic cmdRead = 1'b0;
   logic [7:0] cmdReg = 8'h00;
   logic [7:0] cmdData = 8'h00;
   logic swResetReq = 1'b0;
   logic cmdReady, rspValid, rspNack, initRequired, oscStable, supplyLoss, busBusy, loss2, ack;
   logic [7:0] rspData, seconds, rd, s0;
   logic [31:0] lf = 32'h0229;
   logic [7:0] mem [256];
   int fail_count = 0;
   int cmp_count = 0;
   riapog_if b1();
   riapog_if b2();
   // Short timings so a whole run stays small; the second device gets the short timeout
   localparam int DIV = 4;
   localparam int STAB = 4;
   localparam int SECT = 8;
   localparam int TO_LONG = 1000;
   localparam int TO_SHORT = 100;
   localparam int QD = 4;
   localparam int BLACK = 100;
   localparam int OSCW = 100;
   localparam int RWAIT = 50;
   always #2 sys_clk = !sys_clk;
   riapog_host #(.QDIV(QD), .BLACKOUT_CYC(BLACK), .OSC_START_CYC(OSCW), .RSTWAIT_CYC(RWAIT))
      riapog_host_i (.sys_clk(sys_clk), .rst(rst), .bus(b1.host),
      .supplyGood(supplyGood), .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdReg(cmdReg),
      .cmdData(cmdData), .swResetReq(swResetReq), .cmdReady(cmdReady), .rspValid(rspValid),
      .rspData(rspData), .rspNack(rspNack), .initRequired(initRequired));
   riapog_device #(.OSC_DIV(DIV), .TIMEOUT_TICKS(TO_LONG), .STABLE_TICKS(STAB), .SEC_TICKS(SECT))
      riapog_device_i (.sys_clk(sys_clk), .rst(rst), .bus(b1.device), .supplyRise(supplyRise),
      .oscStable(oscStable), .supplyLoss(supplyLoss), .busBusy(busBusy), .seconds(seconds));
   riapog_device #(.OSC_DIV(DIV), .TIMEOUT_TICKS(TO_SHORT), .STABLE_TICKS(STAB), .SEC_TICKS(SECT))
      riapog_device_i2 (.sys_clk(sys_clk), .rst(rst), .bus(b2.device), .supplyRise(supplyRise),
      .oscStable(), .supplyLoss(loss2), .busBusy(), .seconds());
   riapog_sva riapog_sva_i (.sys_clk(sys_clk), .rst(rst), .scl(b1.scl), .sda(b1.sda),
      .sdaDevOe(b1.sdaDevOe), .supplyRise(supplyRise), .supplyGood(supplyGood),
      .busBusy(busBusy), .seconds(seconds), .supplyLoss(supplyLoss), .oscStable(oscStable),
      .cmdReady(cmdReady));
   // ****************
   // Tasks
   // ****************
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic chkb(input logic g, input logic e);
      chk({7'h00, g}, {7'h00, e});
   endtask : chkb
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic wready();
      int n;
      n = 0;
      while (cmdReady !== 1'b1 && n < 20000)
      begin
         tick(1);
         n++;
      end
      if (n == 20000) fail_count++;
   endtask : wready
   task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
      int n;
      wready();
      cmdRead = r;
      cmdReg = a;
      cmdData = d;
      cmdValid = 1'b1;
      tick(1);
      cmdValid = 1'b0;
      n = 0;
      while (rspValid !== 1'b1 && n < 5000)
      begin
         tick(1);
         n++;
      end
      if (n == 5000) fail_count++;
      rd = rspData;
      chkb(rspNack, 1'b0);
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b0, a, d);
      mem[a] = d;
   endtask : wr
   task automatic rdchk(input logic [7:0] a);
      acc(1'b1, a, 8'h00);
      chk(rd, mem[a]);
   endtask : rdchk
   // One quarter bit time on the second bus, levels given as seen on the wire
   task automatic q(input logic c, input logic d);
      b2.sclHostOe = !c;
      b2.sdaHostOe = !d;
      tick(4);
   endtask : q
   task automatic bitx(input logic v);
      q(1'b0, v);
      q(1'b1, v);
      q(1'b1, v);
      q(1'b0, v);
   endtask : bitx
   task automatic bb(input logic [7:0] d, input logic e);
      for (int i = 7; i >= 0; i--)
         bitx(d[i]);
      q(1'b0, 1'b1);
      q(1'b1, 1'b1);
      ack = !b2.sda;
      q(1'b1, 1'b1);
      q(1'b0, 1'b1);
      chkb(ack, e);
   endtask : bb
   task automatic start();
      q(1'b0, 1'b1);
      q(1'b1, 1'b1);
      q(1'b1, 1'b0);
      q(1'b0, 1'b0);
   endtask : start
   task automatic stop();
      q(1'b0, 1'b0);
      q(1'b1, 1'b0);
      q(1'b1, 1'b1);
   endtask : stop
   task automatic results();
      $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   // ****************
   // Sequence
   // ****************
   // Whole run is about 20k cycles; allow more than twice that
   initial
   begin
      #200000;
      fail_count++;
      results();
   end
   initial
   begin
      b2.sclHostOe = 1'b0;
      b2.sdaHostOe = 1'b0;
      tick(12);
      rst = 1'b0;
      wready();
      chkb(initRequired, 1'b1);
      chkb(supplyLoss, 1'b1);
      wr(8'h1e, 8'h00);
      chkb(supplyLoss, 1'b0);
      chkb(initRequired, 1'b0);
      wr(8'h20, 8'hff);
      wr(8'hff, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         lf = nxt(lf);
         wr({2'b01, lf[5:0]}, lf[15:8]);
         rdchk({2'b01, lf[5:0]});
      end
      rdchk(8'h20);
      s0 = seconds;
      tick(40);
      chkb(seconds != s0, 1'b1);
      swResetReq = 1'b1;
      tick(1);
      swResetReq = 1'b0;
      tick(2);
      wready();
      chkb(initRequired, 1'b1);
      mem[8'h3f] = 8'h80;
      mem[8'hd0] = 8'h6c;
      rdchk(8'h3f);
      rdchk(8'hd0);
      supplyRise = 1'b0;
      tick(1);
      supplyRise = 1'b1;
      tick(40);
      chkb(supplyLoss, 1'b1);
      mem[8'h3f] = 8'h00;
      rdchk(8'h3f);
      supplyGood = 1'b0;
      tick(4);
      supplyGood = 1'b1;
      tick(2);
      wready();
      chkb(initRequired, 1'b1);
      start();
      bb(8'h64, 1'b1);
      bb(8'h1e, 1'b1);
      repeat (4) bitx(1'b0);
      stop();
      chkb(loss2, 1'b1);
      start();
      bb(8'h64, 1'b1);
      tick(450);
      bb(8'h1e, 1'b0);
      bb(8'h00, 1'b0);
      stop();
      chkb(loss2, 1'b1);
      start();
      bb(8'h64, 1'b1);
      bb(8'h1e, 1'b1);
      bb(8'h00, 1'b1);
      stop();
      chkb(loss2, 1'b0);
      results();
   end
endmodule : riapog_test
